// >>> core/cdrfa_pkg.sv
// shared constants, types and helpers for the frequency acquisition and loop settings block
package cdrfa_pkg;
  // register offsets
  localparam logic [7:0] REG_LOOP_A = 8'h10;
  localparam logic [7:0] REG_LOOP_D = 8'h13;
  localparam logic [7:0] REG_SHIFT = 8'h14;
  localparam logic [7:0] REG_SLICE = 8'h15;
  localparam logic [7:0] REG_TRIM = 8'h73;
  // reset values
  localparam logic [7:0] RST_LOOP_A = 8'h04;
  localparam logic [7:0] RST_LOOP_D = 8'h06;
  localparam logic [7:0] RST_SHIFT = 8'h00;
  localparam logic [7:0] RST_SLICE = 8'h00;
  // field positions
  localparam int BW_LSB = 0;
  localparam int EDGE_LSB = 3;
  localparam int SLEW_LSB = 0;
  localparam int ADAPT_BIT = 2;
  localparam int PHASE_LSB = 0;
  localparam int EXT_BIT = 7;
  // edge select codes
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  // frequency thresholds in ppm
  localparam logic [15:0] UNLOCK_PPM = 16'h03E8;
  localparam logic [15:0] LOCK_PPM = 16'h00FA;
  // slice scaling: microvolts per code step, extended multiplier, zero code
  localparam int SLICE_STEP_UV = 240;
  localparam int SLICE_EXT_MUL = 6;
  localparam logic [6:0] SLICE_MID = 7'h40;
  // answer to an unmapped read
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } cdrfa_wr_t;

  typedef struct packed {
    logic unlocked;
    logic fll_en;
    logic oct_phase;
  } cdrfa_acq_t;

  // magnitude of a signed ppm error
  function automatic logic [15:0] ppm_mag(input logic signed [15:0] e);
    ppm_mag = e[15] ? 16'(-e) : 16'(e);
  endfunction

  // slice level in microvolts, normal or sixfold range
  function automatic logic signed [17:0] slice_uv_f(input logic [6:0] c, input logic ext);
    logic signed [17:0] d;
    d = $signed({11'h000, c}) - $signed({11'h000, SLICE_MID});
    slice_uv_f = ext ? 18'(d * SLICE_STEP_UV * SLICE_EXT_MUL) : 18'(d * SLICE_STEP_UV);
  endfunction
endpackage

// >>> core/cdrfa_i2c.sv
// serial two-wire register port: address match, pointer, byte writes and reads
`timescale 1ns/10ps
`default_nettype none
module cdrfa_i2c
  import cdrfa_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary bus address
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // register side
  output cdrfa_wr_t wr,
  output logic [7:0] ptr,
  input wire logic [7:0] rd_data
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_PTR, S_WR, S_ACK, S_RD, S_MACK} cdrfa_i2c_st_t;
  cdrfa_i2c_st_t st, nxt;
  logic scl_q, sda_q, rw, mack_ok;
  logic [3:0] cnt;
  logic [7:0] sh;
  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire start_c = scl_i & sda_q & ~sda_i;
  wire stop_c = scl_i & ~sda_q & sda_i;
  wire rx_st = (st == S_ADDR) || (st == S_PTR) || (st == S_WR);

  // pin history for edge and condition detection
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_o <= 1'b0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // byte engine
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= S_IDLE;
      nxt <= S_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      rw <= 1'b0;
      mack_ok <= 1'b0;
      ptr <= 8'h00;
      sda_oe_n <= 1'b1;
      wr <= '0;
    end else begin
      wr.we <= 1'b0;
      if (start_c) begin
        st <= S_ADDR;
        cnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_c) begin
        st <= S_IDLE;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        if (rx_st) begin
          sh <= {sh[6:0], sda_i};
          cnt <= cnt + 4'h1;
        end else if (st == S_RD) begin
          cnt <= cnt + 4'h1;
        end else if (st == S_MACK) begin
          mack_ok <= ~sda_i;
        end
      end else if (scl_fall) begin
        if (rx_st && cnt == 4'h8) begin
          cnt <= 4'h0;
          sda_oe_n <= 1'b0;
          st <= S_ACK;
          if (st == S_ADDR) begin
            rw <= sh[0];
            nxt <= sh[0] ? S_RD : S_PTR;
            if (sh[7:1] != DEV_ADDR) begin
              st <= S_IDLE;
              sda_oe_n <= 1'b1;
            end
          end else if (st == S_PTR) begin
            ptr <= sh;
            nxt <= S_WR;
          end else begin
            wr <= '{we: 1'b1, addr: ptr, data: sh};
            ptr <= ptr + 8'h01;
            nxt <= S_WR;
          end
        end else if (st == S_ACK || (st == S_MACK && mack_ok)) begin
          st <= nxt;
          cnt <= 4'h0;
          sda_oe_n <= 1'b1;
          if (nxt == S_RD) begin
            sh <= rd_data;
            ptr <= ptr + 8'h01;
            sda_oe_n <= rd_data[7];
          end
        end else if (st == S_MACK) begin
          st <= S_IDLE;
        end else if (st == S_RD) begin
          if (cnt == 4'h8) begin
            sda_oe_n <= 1'b1;
            st <= S_MACK;
            nxt <= S_RD;
          end else begin
            sh <= {sh[6:0], 1'b0};
            sda_oe_n <= sh[6];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/cdrfa_acq.sv
// frequency acquisition state machine: octave search, oscillator tuning, lock hysteresis
`timescale 1ns/10ps
`default_nettype none
module cdrfa_acq
  import cdrfa_pkg::*;
#(
  parameter int OSC_W = 10,
  parameter int DIV_W = 3
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // frequency measurement, positive when sampling runs faster than data
  input wire logic meas_valid,
  input wire logic signed [15:0] err_ppm,
  // oscillator and divider control
  output logic [OSC_W-1:0] osc,
  output logic [DIV_W-1:0] div_log2,
  output cdrfa_acq_t stat
);
  typedef enum logic [1:0] {A_OCT, A_TUNE, A_LOCK} cdrfa_acq_st_t;
  localparam logic [OSC_W-1:0] STEP_INIT = OSC_W'(1) << (OSC_W - 3);
  localparam logic [OSC_W-1:0] OSC_MAX = '1;
  localparam logic [DIV_W-1:0] DIV_MAX = '1;
  cdrfa_acq_st_t st;
  logic [OSC_W-1:0] step;
  logic dir_up;
  wire [15:0] mag = ppm_mag(err_ppm);
  wire fast = ~err_ppm[15] && (err_ppm != 16'h0000);
  wire [OSC_W:0] up_sum = {1'b0, osc} + {1'b0, step};
  wire [OSC_W-1:0] osc_up = up_sum[OSC_W] ? OSC_MAX : up_sum[OSC_W-1:0];
  wire [OSC_W-1:0] osc_dn = (osc > step) ? osc - step : '0;
  wire turn = (dir_up == fast);
  wire [OSC_W-1:0] step_nx = (turn && step != OSC_W'(1)) ? step >> 1 : step;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= A_OCT;
      osc <= '0;
      div_log2 <= '0;
      step <= STEP_INIT;
      dir_up <= 1'b1;
      stat <= '{unlocked: 1'b1, fll_en: 1'b1, oct_phase: 1'b1};
    end else if (meas_valid) begin
      case (st)
        A_OCT: begin
          if (fast && div_log2 != DIV_MAX) begin
            div_log2 <= div_log2 + DIV_W'(1);
          end else begin
            st <= A_TUNE;
            stat.oct_phase <= 1'b0;
            if (!fast) begin
              osc <= osc_up;
            end
          end
        end
        A_TUNE: begin
          if (mag <= LOCK_PPM) begin
            st <= A_LOCK;
            stat.unlocked <= 1'b0;
            stat.fll_en <= 1'b0;
          end else begin
            step <= step_nx;
            dir_up <= ~fast;
            osc <= fast ? osc_dn : osc_up;
          end
        end
        default: begin
          if (mag > UNLOCK_PPM) begin
            st <= A_OCT;
            stat <= '{unlocked: 1'b1, fll_en: 1'b1, oct_phase: 1'b1};
            osc <= '0;
            div_log2 <= '0;
            step <= STEP_INIT;
            dir_up <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> core/cdrfa_top.sv
// recovery loop control: register file, acquisition, slice, edge, slew, phase and bandwidth outputs
`timescale 1ns/10ps
`default_nettype none
module cdrfa_top
  import cdrfa_pkg::*;
#(
  parameter int OSC_W = 10,
  parameter int DIV_W = 3,
  parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary bus address
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // configuration port pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // frequency detector and rate
  input wire logic freq_meas_valid,
  input wire logic signed [15:0] freq_err_ppm,
  input wire logic rate_high,
  // factory trim value
  input wire logic [6:0] trim_code,
  // acquisition outputs
  output logic lock_loss_flag,
  output logic [OSC_W-1:0] digital_oscillator,
  output logic [DIV_W-1:0] div_log2,
  output logic fll_en,
  output logic pd_dll_en,
  output logic pd_pll_en,
  // slicer outputs
  output logic offset_loop_en,
  output logic slice_en,
  output logic signed [17:0] slice_uv,
  // phase detector and loop settings
  output logic edge_rise_en,
  output logic edge_fall_en,
  output logic [2:0] dll_track_qui,
  output logic signed [3:0] sample_shift,
  output logic [2:0] jitter_bw_scale
);
  cdrfa_wr_t wr;
  cdrfa_acq_t acq;
  logic [7:0] ptr;
  logic [7:0] loop_control_a;
  logic [7:0] loop_control_d;
  logic [7:0] sampling_shift_control;
  logic [7:0] threshold_offset_control;
  logic [7:0] trimmed_offset_readback;
  logic trim_taken;
  logic [7:0] rd_data;

  // configuration port
  cdrfa_i2c #(
    .DEV_ADDR(DEV_ADDR)
  ) u_i2c (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n),
    .wr(wr),
    .ptr(ptr),
    .rd_data(rd_data)
  );

  // frequency acquisition
  cdrfa_acq #(
    .OSC_W(OSC_W),
    .DIV_W(DIV_W)
  ) u_acq (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .meas_valid(freq_meas_valid),
    .err_ppm(freq_err_ppm),
    .osc(digital_oscillator),
    .div_log2(div_log2),
    .stat(acq)
  );

  // acquisition status to ports
  assign lock_loss_flag = acq.unlocked;
  assign fll_en = acq.fll_en;

  // write decode
  wire we_a = wr.we && (wr.addr == REG_LOOP_A);
  wire we_d = wr.we && (wr.addr == REG_LOOP_D);
  wire we_s = wr.we && (wr.addr == REG_SHIFT);
  wire we_t = wr.we && (wr.addr == REG_SLICE);

  // register file, the trim readback is not writable
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      loop_control_a <= RST_LOOP_A;
      loop_control_d <= RST_LOOP_D;
      sampling_shift_control <= RST_SHIFT;
      threshold_offset_control <= RST_SLICE;
    end else begin
      if (we_a) begin
        loop_control_a <= wr.data;
      end
      if (we_d) begin
        loop_control_d <= wr.data;
      end
      if (we_s) begin
        sampling_shift_control <= wr.data;
      end
      if (we_t) begin
        threshold_offset_control <= wr.data;
      end
    end
  end

  // trim value caught once after reset release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trim_taken <= 1'b0;
      trimmed_offset_readback <= 8'h00;
    end else if (!trim_taken) begin
      trim_taken <= 1'b1;
      trimmed_offset_readback <= {1'b0, trim_code};
    end
  end

  // read selection
  assign rd_data = (ptr == REG_LOOP_A) ? loop_control_a :
                   (ptr == REG_LOOP_D) ? loop_control_d :
                   (ptr == REG_SHIFT) ? sampling_shift_control :
                   (ptr == REG_SLICE) ? threshold_offset_control :
                   (ptr == REG_TRIM) ? trimmed_offset_readback :
                   RD_UNMAPPED;

  // field extraction
  wire [2:0] bw_f = loop_control_a[BW_LSB +: 3];
  wire [1:0] edge_f = loop_control_a[EDGE_LSB +: 2];
  wire [1:0] slew_f = loop_control_d[SLEW_LSB +: 2];
  wire adapt_f = loop_control_d[ADAPT_BIT];
  wire [3:0] phase_f = sampling_shift_control[PHASE_LSB +: 4];
  wire [6:0] slice_code = threshold_offset_control[6:0];
  wire slice_ext = threshold_offset_control[EXT_BIT];

  // derived settings
  wire next_slice_en = (slice_code != 7'h00);
  wire signed [17:0] next_slice_uv = next_slice_en ? slice_uv_f(slice_code, slice_ext) : 18'sh00000;
  wire next_rise = (edge_f != EDGE_FALL);
  wire next_fall = (edge_f != EDGE_RISE);
  wire [2:0] next_track = {1'b0, slew_f} + 3'h1;
  wire [3:0] next_shift = rate_high ? phase_f : 4'h0;

  // registered loop settings
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      offset_loop_en <= 1'b0;
      slice_en <= 1'b0;
      slice_uv <= 18'sh00000;
      edge_rise_en <= 1'b1;
      edge_fall_en <= 1'b1;
      dll_track_qui <= 3'h1;
      sample_shift <= 4'sh0;
      jitter_bw_scale <= 3'h0;
    end else begin
      offset_loop_en <= adapt_f;
      slice_en <= next_slice_en;
      slice_uv <= next_slice_uv;
      edge_rise_en <= next_rise;
      edge_fall_en <= next_fall;
      dll_track_qui <= next_track;
      sample_shift <= $signed(next_shift);
      jitter_bw_scale <= bw_f;
    end
  end

  // phase detector feeds both loops once locked, at any division ratio
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_dll_en <= 1'b0;
      pd_pll_en <= 1'b0;
    end else begin
      pd_dll_en <= ~acq.unlocked;
      pd_pll_en <= ~acq.unlocked;
    end
  end

  // checks
  localparam logic [OSC_W-1:0] OSC_TOP = '1;
  localparam logic [DIV_W-1:0] DIV_TOP = '1;
  wire [15:0] err_mag = ppm_mag(freq_err_ppm);
  wire err_fast = ~freq_err_ppm[15] && (freq_err_ppm != 16'h0000);

  sequence lock_lost_s;
    !lock_loss_flag && freq_meas_valid && (err_mag > UNLOCK_PPM);
  endsequence

  sequence lock_won_s;
    lock_loss_flag && !acq.oct_phase && freq_meas_valid && (err_mag <= LOCK_PPM);
  endsequence

  property restart_p;
    @(posedge ref_clk) disable iff (!arst_n)
      lock_lost_s |=> lock_loss_flag && fll_en ##1 !pd_pll_en && !pd_dll_en;
  endproperty

  unlock_restart_a: assert property (restart_p) else $error("lock loss not raised on large error");

  acq_restart_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    lock_lost_s |=> (digital_oscillator == '0) && (div_log2 == '0))
    else $error("acquisition did not restart at bottom");

  oct_double_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    acq.oct_phase && freq_meas_valid && err_fast && (div_log2 != DIV_TOP)
    |=> div_log2 == $past(div_log2) + DIV_W'(1))
    else $error("division ratio not doubled");

  osc_raise_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    lock_loss_flag && !acq.oct_phase && freq_meas_valid && freq_err_ppm[15]
    && (err_mag > LOCK_PPM) && (digital_oscillator != OSC_TOP)
    |=> digital_oscillator > $past(digital_oscillator))
    else $error("oscillator not raised");

  relock_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    lock_won_s |=> !lock_loss_flag && !fll_en ##1 pd_pll_en && pd_dll_en)
    else $error("lock not declared within window");

  fll_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !lock_loss_flag |-> !fll_en)
    else $error("frequency loop left on while locked");

  slice_map_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ##1 (slice_en == ($past(slice_code) != 7'h00))
    && (slice_uv == ($past(slice_code) == 7'h00 ? 18'sh00000 :
    slice_uv_f($past(slice_code), $past(slice_ext)))))
    else $error("slice output does not follow code");

  offset_loop_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    we_d && !wr.data[ADAPT_BIT] |=> ##1 !offset_loop_en)
    else $error("offset loop still running after disable");

  edge_sel_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ##1 (edge_rise_en == ($past(edge_f) != EDGE_FALL))
    && (edge_fall_en == ($past(edge_f) != EDGE_RISE)))
    else $error("edge selection mismatch");

  slew_track_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    we_d |=> ##1 dll_track_qui == {1'b0, $past(wr.data[SLEW_LSB +: 2], 2)} + 3'h1)
    else $error("slew tracking mismatch");

  shift_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !rate_high |=> sample_shift == 4'sh0)
    else $error("phase shift applied at low rate");

  bw_scale_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    we_a |=> ##1 jitter_bw_scale == $past(wr.data[BW_LSB +: 3], 2))
    else $error("bandwidth scale not applied");

  // the trim pins are caught on the first edge after reset and then held
  trim_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(trim_taken) |-> trimmed_offset_readback == {1'b0, $past(trim_code)})
    else $error("trim value not captured");
endmodule
`default_nettype wire

// >>> bench/cdrfa_host.sv
// two-wire configuration host model with open-drain data line
`timescale 1ns/10ps
`default_nettype none
module cdrfa_host
  import cdrfa_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // device side of the data line
  input wire logic sda_o,
  input wire logic sda_oe_n,
  // bus lines
  output logic scl,
  output logic sda
);
  logic drv = 1'b1;
  initial scl = 1'b1;
  // wired-and line with pull-up, released high
  assign sda = drv & (sda_oe_n | sda_o);
  // four clocks per bus phase, above the three-clock minimum
  task automatic tick();
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic bit_io(input logic b, output logic s);
    drv = b;
    tick();
    scl = 1'b1;
    tick();
    s = sda;
    scl = 1'b0;
    tick();
  endtask
  // start or repeated start
  task automatic start();
    drv = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    drv = 1'b0;
    tick();
    scl = 1'b0;
  endtask
  task automatic stop();
    drv = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    drv = 1'b1;
    tick();
  endtask
  // msb first; a one in the ack slot releases the line
  task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // settings the host computes itself and writes whole
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ack);
    logic [7:0] r;
    logic k;
    start();
    byte_io({dev, 1'b0}, r, ack);
    byte_io(a, r, k);
    byte_io(d, r, k);
    stop();
  endtask
  // pointer write, repeated start, one byte read ended by nack
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    logic k;
    start();
    byte_io(8'h54, r, k);
    byte_io(a, r, k);
    start();
    byte_io(8'h55, r, k);
    byte_io(8'hFF, d, k);
    stop();
  endtask
endmodule
`default_nettype wire

// >>> bench/cdrfa_top_tb.sv
// self-checking bench for acquisition and loop settings
`timescale 1ns/10ps
`default_nettype none
module cdrfa_top_tb
  import cdrfa_pkg::*;
;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic [2:0] sel;
    logic [17:0] exp;
  } cdrfa_row_t;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic scl, sda, sda_o, sda_oe_n, rate_high = 1'b1, freq_meas_valid = 1'b0;
  logic signed [15:0] freq_err_ppm = 16'h0000;
  logic [6:0] trim_code = 7'h35;
  logic lock_loss_flag, fll_en, pd_dll_en, pd_pll_en, offset_loop_en, slice_en, edge_rise_en, edge_fall_en;
  logic [9:0] digital_oscillator;
  logic [2:0] div_log2, dll_track_qui, jitter_bw_scale;
  logic signed [17:0] slice_uv;
  logic signed [3:0] sample_shift;
  logic [7:0] rd_val;
  logic ack;
  int fails = 0;
  int checks_done = 0;
  // address 0 means check only; sel picks the output
  cdrfa_row_t rows [0:23] = '{
    '{8'h15, 8'h00, 3'h0, 18'h0}, '{8'h00, 8'h00, 3'h1, 18'h0},
    '{8'h15, 8'h01, 3'h1, 18'h3C4F0}, '{8'h00, 8'h00, 3'h0, 18'h1},
    '{8'h15, 8'h40, 3'h1, 18'h0}, '{8'h15, 8'h7F, 3'h1, 18'h3B10},
    '{8'h15, 8'h81, 3'h1, 18'h29DA0}, '{8'h15, 8'hFF, 3'h1, 18'h16260},
    '{8'h15, 8'h80, 3'h0, 18'h0}, '{8'h10, 8'h0C, 3'h2, 18'h2},
    '{8'h00, 8'h00, 3'h5, 18'h4}, '{8'h10, 8'h13, 3'h2, 18'h1},
    '{8'h00, 8'h00, 3'h5, 18'h3}, '{8'h10, 8'h1F, 3'h2, 18'h3},
    '{8'h00, 8'h00, 3'h5, 18'h7}, '{8'h10, 8'h01, 3'h2, 18'h3},
    '{8'h00, 8'h00, 3'h5, 18'h1}, '{8'h13, 8'h00, 3'h3, 18'h1},
    '{8'h00, 8'h00, 3'h6, 18'h0}, '{8'h13, 8'h07, 3'h3, 18'h4},
    '{8'h00, 8'h00, 3'h6, 18'h1}, '{8'h14, 8'h07, 3'h4, 18'h7},
    '{8'h14, 8'h08, 3'h4, 18'h3FFF8}, '{8'h00, 8'h00, 3'h1, 18'h0}};

  cdrfa_top cdrfa_top_i (.ref_clk, .arst_n, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_n, .freq_meas_valid,
    .freq_err_ppm, .rate_high, .trim_code, .lock_loss_flag, .digital_oscillator, .div_log2, .fll_en, .pd_dll_en,
    .pd_pll_en, .offset_loop_en, .slice_en, .slice_uv, .edge_rise_en, .edge_fall_en, .dll_track_qui,
    .sample_shift, .jitter_bw_scale);
  cdrfa_host cdrfa_host_i (.ref_clk, .sda_o, .sda_oe_n, .scl, .sda);

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  function automatic logic [17:0] obs(input logic [2:0] s);
    case (s)
      3'h0: obs = {17'h0, slice_en};
      3'h1: obs = slice_uv;
      3'h2: obs = {16'h0, edge_rise_en, edge_fall_en};
      3'h3: obs = {15'h0, dll_track_qui};
      3'h4: obs = {{14{sample_shift[3]}}, sample_shift};
      3'h5: obs = {15'h0, jitter_bw_scale};
      default: obs = {17'h0, offset_loop_en};
    endcase
  endfunction
  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    cdrfa_host_i.rd(a, rd_val);
    check($sformatf("reg %h", a), {10'h0, exp}, {10'h0, rd_val});
  endtask
  // one measurement pulse, then settle past the lock follow-up
  task automatic meas(input logic signed [15:0] e);
    @(negedge ref_clk);
    freq_meas_valid = 1'b1;
    freq_err_ppm = e;
    @(negedge ref_clk);
    freq_meas_valid = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic acq(input logic [9:0] osc, input logic [2:0] dv, input logic unl);
    check("osc", {8'h0, osc}, {8'h0, digital_oscillator});
    check("div", {15'h0, dv}, {15'h0, div_log2});
    check("unlock fll", {16'h0, unl, unl}, {16'h0, lock_loss_flag, fll_en});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    acq(10'h000, 3'h0, 1'b1);
    check("bw", 18'h4, obs(3'h5));
    check("track", 18'h3, obs(3'h3));
    check("adapt", 18'h1, obs(3'h6));
    rdchk(REG_LOOP_A, RST_LOOP_A);
    rdchk(REG_LOOP_D, RST_LOOP_D);
    rdchk(REG_SHIFT, RST_SHIFT);
    rdchk(REG_SLICE, RST_SLICE);
    rdchk(REG_TRIM, 8'h35);
    rdchk(8'h20, RD_UNMAPPED);
    $display("reset test done");
    foreach (rows[i]) begin
      if (rows[i].addr != 8'h00) cdrfa_host_i.wr(7'h2A, rows[i].addr, rows[i].data, ack);
      check($sformatf("row %0d", i), rows[i].exp, obs(rows[i].sel));
    end
    $display("table test done");
    rdchk(REG_SHIFT, 8'h08);
    rate_high = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("shift low rate", 18'h0, obs(3'h4));
    cdrfa_host_i.wr(7'h2A, REG_TRIM, 8'hFF, ack);
    rdchk(REG_TRIM, 8'h35);
    cdrfa_host_i.wr(7'h2B, REG_SLICE, 8'h7F, ack);
    check("foreign ack", 18'h0, {17'h0, ack});
    check("foreign write", 18'h0, obs(3'h1));
    // manual slice: adaptive loop off, code from wanted 0 mV minus the trimmed offset
    cdrfa_host_i.wr(7'h2A, REG_LOOP_D, 8'h02, ack);
    check("adapt off", 18'h0, obs(3'h6));
    cdrfa_host_i.rd(REG_TRIM, rd_val);
    cdrfa_host_i.wr(7'h2A, REG_SLICE, 8'h80 - rd_val, ack);
    check("manual slice", 18'h00A50, obs(3'h1));
    $display("register edge test done");
    meas(16'sd5000);
    acq(10'h000, 3'h1, 1'b1);
    meas(16'sd5000);
    acq(10'h000, 3'h2, 1'b1);
    meas(-16'sd5000);
    acq(10'h080, 3'h2, 1'b1);
    meas(-16'sd5000);
    acq(10'h100, 3'h2, 1'b1);
    meas(16'sd100);
    acq(10'h100, 3'h2, 1'b0);
    check("pd", 18'h3, {16'h0, pd_dll_en, pd_pll_en});
    meas(16'sd900);
    acq(10'h100, 3'h2, 1'b0);
    meas(16'sd1001);
    acq(10'h000, 3'h0, 1'b1);
    // direction changes halve the tuning step
    meas(-16'sd5000);
    acq(10'h080, 3'h0, 1'b1);
    meas(16'sd5000);
    acq(10'h000, 3'h0, 1'b1);
    meas(-16'sd5000);
    acq(10'h040, 3'h0, 1'b1);
    meas(-16'sd5000);
    acq(10'h060, 3'h0, 1'b1);
    meas(16'sd200);
    acq(10'h060, 3'h0, 1'b0);
    $display("acquisition test done");
    summarize();
  end

  // watchdog at nearly three times the expected run of some 11000 cycles
  initial begin
    #600000;
    fails++;
    $display("watchdog expired");
    summarize();
  end
endmodule
`default_nettype wire
